// file: include/fcs_regs.svh
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH

// Register offsets
`define FCS_REG_CTRL 8'h00
`define FCS_REG_ADDR 8'h04
`define FCS_REG_WDATA 8'h08
`define FCS_REG_SECT 8'h0C
`define FCS_REG_STAT 8'h10
`define FCS_REG_RDATA 8'h14

// Field positions
`define FCS_CTRL_START_BIT 8
`define FCS_STAT_BUSY_BIT 0
`define FCS_STAT_DONE_BIT 1
`define FCS_STAT_FAIL_BIT 2
`define FCS_STAT_REJECT_BIT 3
`define FCS_STAT_RAW_LSB 8

// Reset values
`define FCS_ADDR_RST 17'h00000
`define FCS_WDATA_RST 8'hFF
`define FCS_SECT_RST 8'h00

// Flash status bit positions
`define FCS_DQ_POLL 7
`define FCS_DQ_TLIM 5

// Flash command words
`define FCS_ADR_UNLOCK1 17'h05555
`define FCS_ADR_UNLOCK2 17'h02AAA
`define FCS_DAT_UNLOCK1 8'hAA
`define FCS_DAT_UNLOCK2 8'h55
`define FCS_CMD_RESET 8'hF0
`define FCS_CMD_ID 8'h90
`define FCS_CMD_PROG 8'hA0
`define FCS_CMD_ERASE 8'h80
`define FCS_CMD_CHIP 8'h10
`define FCS_CMD_SECT 8'h30
`define FCS_SECT_SHIFT 14

// AXI responses
`define FCS_RESP_OKAY 2'h0
`define FCS_RESP_SLVERR 2'h2

// Timing
`define FCS_CLK_PERIOD_NS 25
`define FCS_T_WP_NS 50
`define FCS_T_ACC_NS 120
`define FCS_T_SE_WINDOW_NS 80000
`define FCS_SYNC_STAGES 2
`define FCS_WP_CYC \
    ((`FCS_T_WP_NS + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS)
`define FCS_RD_CYC ((`FCS_T_ACC_NS + `FCS_CLK_PERIOD_NS - 1) \
    / `FCS_CLK_PERIOD_NS + `FCS_SYNC_STAGES)
`define FCS_SE_WIN_CYC (`FCS_T_SE_WINDOW_NS / `FCS_CLK_PERIOD_NS)

`endif

// file: include/fcs_pkg.sv
package fcs_pkg;

    typedef enum logic [2:0] {
        FCS_OP_READ, FCS_OP_RESET, FCS_OP_ID,
        FCS_OP_PROG, FCS_OP_CHIP, FCS_OP_SECT
    } fcs_op_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_WR, ST_RD, ST_POLL, ST_FINAL
    } fcs_state_t;

    typedef enum logic [1:0] {
        PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD
    } fcs_ph_t;

endpackage

// file: include/fcs_cyc_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fcs_cyc_if;
    logic req;
    logic wr;
    logic [16:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    modport host(output req, wr, addr, wdata, input done, rdata);
    modport target(input req, wr, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

// file: design/fcs_pin_cycle.sv
`timescale 1ns/100ps
`default_nettype none
`include "fcs_regs.svh"
module fcs_pin_cycle #(
    parameter int WP_CYC = `FCS_WP_CYC,
    parameter int RD_CYC = `FCS_RD_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus cycle requests
    fcs_cyc_if.target cyc,
    // Flash pins
    output logic [16:0] flash_addr,
    input wire logic [7:0] flash_dq_i,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe,
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n
);
    import fcs_pkg::*;

    if (WP_CYC < 1 || WP_CYC > 255 || RD_CYC < 3 || RD_CYC > 255)
    begin : g_bad_param
        $error("fcs_pin_cycle: unsupported cycle counts");
    end

    typedef struct packed {
        fcs_ph_t ph;
        logic wr;
        logic [7:0] cnt;
        logic [16:0] addr;
        logic [7:0] data;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic dq_oe;
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] rdata;
    } fcs_pin_st_t;

    localparam fcs_pin_st_t PIN_RST = '{ph: PH_IDLE, ce_n: 1'b1,
        we_n: 1'b1, oe_n: 1'b1, default: '0};

    fcs_pin_st_t q;
    fcs_pin_st_t d;

    always_comb
    begin
        d = q;
        d.s1 = flash_dq_i;
        d.s2 = q.s1;
        case (q.ph)
            PH_IDLE:
                if (cyc.req)
                begin
                    d.ph = PH_SETUP;
                    d.wr = cyc.wr;
                    d.addr = cyc.addr;
                    d.data = cyc.wdata;
                    d.dq_oe = cyc.wr;
                end
            PH_SETUP:
            begin
                // Address and data settle a cycle ahead of both strobes
                d.ph = PH_STROBE;
                d.ce_n = 1'b0;
                d.we_n = !q.wr;
                d.oe_n = q.wr;
                d.cnt = q.wr ? 8'(WP_CYC - 1) : 8'(RD_CYC - 1);
            end
            PH_STROBE:
                if (q.cnt == 8'h00)
                begin
                    // Both strobes rise together, data still driven
                    d.ph = PH_HOLD;
                    d.ce_n = 1'b1;
                    d.we_n = 1'b1;
                    d.oe_n = 1'b1;
                    if (!q.wr)
                        d.rdata = q.s2;
                end
                else
                    d.cnt = q.cnt - 8'h01;
            PH_HOLD:
            begin
                d.ph = PH_IDLE;
                d.dq_oe = 1'b0;
            end
            default:
                d = PIN_RST;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q <= PIN_RST;
        else
            q <= d;
    end

    assign cyc.done = q.ph == PH_HOLD;
    assign cyc.rdata = q.rdata;
    assign flash_addr = q.addr;
    assign flash_dq_o = q.data;
    assign flash_dq_oe = q.dq_oe;
    assign flash_ce_n = q.ce_n;
    assign flash_we_n = q.we_n;
    assign flash_oe_n = q.oe_n;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_WE_PULSE: assert property ($fell(flash_we_n) |->
        (!flash_we_n && !flash_ce_n && flash_dq_oe)[*2] ##1 flash_we_n)
        else $error("write strobe width wrong");
    AST_WR_STABLE: assert property (!flash_we_n
        || $rose(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_o))
        else $error("address or data moved during write strobe");
    AST_NO_FIGHT: assert property (!flash_oe_n |-> !flash_dq_oe
        && flash_we_n)
        else $error("data bus driven during a read");
endmodule
`default_nettype wire

// file: design/fcs_ctrl.sv
// Contract
// - Identification mode persists until the read/reset sequence is written.
// - Byte program: two unlock writes, program setup, then address and data.
// - Program ends when poll bit matches written bit; poll that address.
// - Chip erase is six writes: unlocks, setup, unlocks, chip erase.
// - Extra sector writes accepted only within 80us of the previous one.
// - Only selected sectors erase; poll inside an erasing sector for one.
// - Poll valid after sixth or last sector write; poll unprotected sector (code polls the lowest selected sector, protected or not).
// - Poll bit may flip before other bits settle; reread for valid data.
// - Unlock AAH at 5555H, 55H at 2AAAH, command byte at 5555H.
`timescale 1ns/100ps
`default_nettype none
`include "fcs_regs.svh"
module fcs_ctrl #(
    parameter int WP_CYC = `FCS_WP_CYC,
    parameter int RD_CYC = `FCS_RD_CYC,
    parameter int SE_WIN_CYC = `FCS_SE_WIN_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Flash pins
    output logic [16:0] flash_addr,
    input wire logic [7:0] flash_dq_i,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe,
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n
);
    import fcs_pkg::*;

    if (SE_WIN_CYC < 16 || SE_WIN_CYC > 8000)
    begin : g_bad_param
        $error("fcs_ctrl: unsupported sector window count");
    end

    typedef struct packed {
        fcs_state_t st;
        fcs_op_t op;
        logic [2:0] step;
        logic [7:0] pend;
        logic [16:0] poll_addr;
        logic retry;
        logic [16:0] addr_r;
        logic [7:0] wdata_r;
        logic [7:0] sect_r;
        logic [2:0] op_r;
        logic done;
        logic fail;
        logic reject;
        logic [7:0] raw;
        logic [7:0] rdata;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdat;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdat;
        logic [1:0] rresp;
    } fcs_ctrl_st_t;

    localparam fcs_ctrl_st_t CTRL_RST = '{st: ST_IDLE, op: FCS_OP_READ,
        addr_r: `FCS_ADDR_RST, wdata_r: `FCS_WDATA_RST,
        sect_r: `FCS_SECT_RST, default: '0};

    fcs_ctrl_st_t q;
    fcs_ctrl_st_t d;

    function automatic logic [7:0] cmd_byte(fcs_op_t op);
        case (op)
            FCS_OP_ID: cmd_byte = `FCS_CMD_ID;
            FCS_OP_PROG: cmd_byte = `FCS_CMD_PROG;
            FCS_OP_CHIP, FCS_OP_SECT: cmd_byte = `FCS_CMD_ERASE;
            default: cmd_byte = `FCS_CMD_RESET;
        endcase
    endfunction

    function automatic logic [2:0] last_step(fcs_op_t op);
        case (op)
            FCS_OP_PROG: last_step = 3'h3;
            FCS_OP_CHIP, FCS_OP_SECT: last_step = 3'h5;
            default: last_step = 3'h2;
        endcase
    endfunction

    function automatic logic [2:0] lowest(logic [7:0] m);
        lowest = 3'h0;
        for (int i = 7; i >= 0; i--)
            if (m[i])
                lowest = 3'(i);
    endfunction

    // Address and data of one command write, as {addr, data}
    function automatic logic [24:0] seq_word(fcs_op_t op, logic [2:0] step,
        logic [16:0] a, logic [7:0] dat, logic [2:0] sec);
        case (step)
            3'h1, 3'h4: seq_word = {`FCS_ADR_UNLOCK2, `FCS_DAT_UNLOCK2};
            3'h2: seq_word = {`FCS_ADR_UNLOCK1, cmd_byte(op)};
            3'h3: seq_word = (op == FCS_OP_PROG) ? {a, dat}
                : {`FCS_ADR_UNLOCK1, `FCS_DAT_UNLOCK1};
            3'h5: seq_word = (op == FCS_OP_CHIP)
                ? {`FCS_ADR_UNLOCK1, `FCS_CMD_CHIP}
                : {sec, 14'h0000, `FCS_CMD_SECT};
            default: seq_word = {`FCS_ADR_UNLOCK1, `FCS_DAT_UNLOCK1};
        endcase
    endfunction

    // Register image with a mapped flag on top
    function automatic logic [32:0] reg_image(logic [7:0] a,
        fcs_ctrl_st_t s);
        case (a)
            `FCS_REG_CTRL: reg_image = {1'b1, 29'h0, s.op_r};
            `FCS_REG_ADDR: reg_image = {1'b1, 15'h0, s.addr_r};
            `FCS_REG_WDATA: reg_image = {1'b1, 24'h0, s.wdata_r};
            `FCS_REG_SECT: reg_image = {1'b1, 24'h0, s.sect_r};
            `FCS_REG_STAT: reg_image = {1'b1, 16'h0, s.raw, 4'h0,
                s.reject, s.fail, s.done, s.st != ST_IDLE};
            `FCS_REG_RDATA: reg_image = {1'b1, 24'h0, s.rdata};
            default: reg_image = 33'h0;
        endcase
    endfunction

    function automatic logic [31:0] strb_merge(logic [31:0] old,
        logic [31:0] nw, logic [3:0] strb);
        for (int i = 0; i < 4; i++)
            if (strb[i])
                old[i*8 +: 8] = nw[i*8 +: 8];
        strb_merge = old;
    endfunction

    fcs_cyc_if cyc();
    logic [2:0] cur_sec;
    logic [24:0] seq_w;
    logic poll_tgt;
    logic [32:0] wimg;
    logic [32:0] rimg;
    logic [31:0] wval;

    assign cur_sec = lowest(q.pend);
    assign seq_w = seq_word(q.op, q.step, q.addr_r, q.wdata_r, cur_sec);
    assign poll_tgt = (q.op == FCS_OP_PROG) ? q.wdata_r[7] : 1'b1;
    assign wimg = reg_image(q.awaddr, q);
    assign rimg = reg_image(s_axi_araddr, q);
    assign wval = strb_merge(wimg[31:0], q.wdat, q.wstrb);

    assign cyc.req = q.st != ST_IDLE;
    assign cyc.wr = q.st == ST_WR;
    assign cyc.addr = (q.st == ST_WR) ? seq_w[24:8]
        : (q.st == ST_RD) ? q.addr_r : q.poll_addr;
    assign cyc.wdata = seq_w[7:0];

    assign s_axi_awready = !q.aw_got && !q.bvalid;
    assign s_axi_wready = !q.w_got && !q.bvalid;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdat;
    assign s_axi_rresp = q.rresp;

    always_comb
    begin
        d = q;
        if (s_axi_awvalid && s_axi_awready)
        begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            d.w_got = 1'b1;
            d.wdat = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready)
            d.bvalid = 1'b0;
        if (q.rvalid && s_axi_rready)
            d.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            d.rvalid = 1'b1;
            d.rdat = rimg[31:0];
            d.rresp = rimg[32] ? `FCS_RESP_OKAY : `FCS_RESP_SLVERR;
        end
        // Command sequencer
        case (q.st)
            ST_WR:
                if (cyc.done)
                begin
                    if (q.step != last_step(q.op))
                        d.step = q.step + 3'h1;
                    else if (q.op == FCS_OP_SECT)
                    begin
                        // Queue sectors back to back inside the window
                        d.pend = q.pend & ~(8'h01 << cur_sec);
                        if (d.pend == 8'h00)
                            d.st = ST_POLL;
                    end
                    else if (q.op == FCS_OP_PROG || q.op == FCS_OP_CHIP)
                        d.st = ST_POLL;
                    else if (q.op == FCS_OP_ID)
                        d.st = ST_RD;
                    else
                    begin
                        d.st = ST_IDLE;
                        d.done = 1'b1;
                    end
                end
            ST_RD:
                if (cyc.done)
                begin
                    d.rdata = cyc.rdata;
                    if (q.op == FCS_OP_ID)
                    begin
                        // Leave identification mode at once
                        d.op = FCS_OP_RESET;
                        d.step = 3'h0;
                        d.st = ST_WR;
                    end
                    else
                    begin
                        d.st = ST_IDLE;
                        d.done = 1'b1;
                    end
                end
            ST_POLL:
                if (cyc.done)
                begin
                    d.raw = cyc.rdata;
                    if (cyc.rdata[`FCS_DQ_POLL] == poll_tgt)
                        d.st = ST_FINAL;
                    else if (cyc.rdata[`FCS_DQ_TLIM])
                    begin
                        // Poll bit rechecked once after a time limit
                        if (q.retry)
                        begin
                            d.fail = 1'b1;
                            d.op = FCS_OP_RESET;
                            d.step = 3'h0;
                            d.st = ST_WR;
                        end
                        else
                            d.retry = 1'b1;
                    end
                end
            ST_FINAL:
                if (cyc.done)
                begin
                    // Reread, low bits may lag the poll bit
                    d.rdata = cyc.rdata;
                    d.st = ST_IDLE;
                    d.done = 1'b1;
                end
            default:
                ;
        endcase
        // Register writes
        if (q.aw_got && q.w_got)
        begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = wimg[32] ? `FCS_RESP_OKAY : `FCS_RESP_SLVERR;
            if (wimg[32] && q.awaddr != `FCS_REG_STAT
                && q.awaddr != `FCS_REG_RDATA)
            begin
                if (q.st != ST_IDLE)
                    d.reject = 1'b1;
                else
                    case (q.awaddr)
                        `FCS_REG_ADDR: d.addr_r = wval[16:0];
                        `FCS_REG_WDATA: d.wdata_r = wval[7:0];
                        `FCS_REG_SECT: d.sect_r = wval[7:0];
                        default:
                        begin
                            d.op_r = wval[2:0];
                            if (wval[`FCS_CTRL_START_BIT])
                            begin
                                d.done = 1'b0;
                                d.fail = 1'b0;
                                d.retry = 1'b0;
                                d.step = 3'h0;
                                d.pend = q.sect_r;
                                if (wval[2:0] > FCS_OP_SECT
                                    || (wval[2:0] == FCS_OP_SECT
                                    && q.sect_r == 8'h00))
                                    d.reject = 1'b1;
                                else
                                begin
                                    d.reject = 1'b0;
                                    d.op = fcs_op_t'(wval[2:0]);
                                    d.st = (d.op == FCS_OP_READ)
                                        ? ST_RD : ST_WR;
                                    d.poll_addr = (d.op == FCS_OP_SECT)
                                        ? {lowest(q.sect_r), 14'h0000}
                                        : q.addr_r;
                                end
                            end
                        end
                    endcase
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q <= CTRL_RST;
        else
            q <= d;
    end

    fcs_pin_cycle #(
        .WP_CYC(WP_CYC),
        .RD_CYC(RD_CYC)
    ) u_pin (
        .aclk(aclk),
        .aresetn(aresetn),
        .cyc(cyc),
        .flash_addr(flash_addr),
        .flash_dq_i(flash_dq_i),
        .flash_dq_o(flash_dq_o),
        .flash_dq_oe(flash_dq_oe),
        .flash_ce_n(flash_ce_n),
        .flash_we_n(flash_we_n),
        .flash_oe_n(flash_oe_n)
    );

    // Cycles since the last sector write
    logic [12:0] se_gap_q;
    logic se_wr_done;
    assign se_wr_done = q.st == ST_WR && q.op == FCS_OP_SECT
        && q.step == 3'h5 && cyc.done;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            se_gap_q <= 13'h0000;
        else if (se_wr_done)
            se_gap_q <= 13'h0000;
        else if (se_gap_q != 13'h1FFF)
            se_gap_q <= se_gap_q + 13'h0001;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_UNLOCK_FIRST: assert property (cyc.wr && q.step == 3'h0 |->
        cyc.addr == `FCS_ADR_UNLOCK1 && cyc.wdata == `FCS_DAT_UNLOCK1)
        else $error("first unlock write wrong");
    AST_PROG_DATA: assert property (cyc.wr && q.op == FCS_OP_PROG
        && q.step == 3'h3 |-> cyc.addr == q.addr_r
        && cyc.wdata == q.wdata_r)
        else $error("program data write wrong");
    AST_CHIP_LAST: assert property (cyc.wr && q.op == FCS_OP_CHIP
        && q.step == 3'h5 |-> cyc.addr == `FCS_ADR_UNLOCK1
        && cyc.wdata == `FCS_CMD_CHIP)
        else $error("chip erase command wrong");
    AST_ID_EXIT: assert property (q.st == ST_RD && q.op == FCS_OP_ID
        && cyc.done |=> q.st == ST_WR && q.op == FCS_OP_RESET
        && q.step == 3'h0)
        else $error("identification mode not left");
    AST_POLL_ADDR: assert property (q.st == ST_POLL
        && q.op == FCS_OP_PROG |-> !cyc.wr && cyc.addr == q.addr_r)
        else $error("program poll at wrong address");
    AST_SECT_POLL: assert property (q.st == ST_POLL
        && q.op == FCS_OP_SECT |-> cyc.addr[13:0] == 14'h0000
        && q.sect_r[cyc.addr[16:14]])
        else $error("sector poll outside erased sectors");
    AST_SE_WINDOW: assert property (se_wr_done
        && q.pend != q.sect_r |-> se_gap_q < SE_WIN_CYC)
        else $error("sector write outside window");
    AST_REREAD: assert property (q.st == ST_POLL && cyc.done
        && cyc.rdata[`FCS_DQ_POLL] == poll_tgt |=> q.st == ST_FINAL
        ##[1:40] q.st == ST_IDLE && q.done)
        else $error("final reread missing");

    COV_PROG: cover property (q.op == FCS_OP_PROG && q.st == ST_FINAL
        ##1 q.st == ST_IDLE);
    COV_MULTI_SECT: cover property (se_wr_done && q.pend != q.sect_r);
    COV_FAIL: cover property ($rose(q.fail));
endmodule
`default_nettype wire

// file: tb/fcs_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module fcs_flash_model (
    // Controller pins
    input wire logic [16:0] addr,
    input wire logic [7:0] dq_o,
    input wire logic we_n,
    input wire logic oe_n,
    // Read data
    output logic [7:0] dq_i
);
    // Codes are arbitrary with odd parity; sector 1 protected
    localparam logic [7:0] MK = 8'h07, PT = 8'h8A, PR = 8'h02;
    logic [7:0] mem [131072], q = 8'h00, pd, sect;
    logic [16:0] la = 17'h00000, pa;
    bit idm, er, win, tog;
    int st, busy;
    time tw;
    initial foreach (mem[i]) mem[i] = 8'hFF;
    // Released bus shows the inverse of the last byte
    assign dq_i = oe_n ? ~q : q;
    task automatic expire;
        if (win && $time - tw >= 80000)
            busy = 4;
        win = win && busy == 0;
    endtask
    task automatic cmd(input logic [16:0] a, input logic [7:0] d);
        win = win && d == 8'h30;
        sect = win ? sect | 8'h01 << a[16:14] : sect;
        if (st == 6)
        begin
            pa = a;
            pd = d;
            er = 0;
            busy = 3;
        end
        if (st == 5)
        begin
            er = 1;
            sect = d == 8'h10 ? 8'hFF : 8'h01 << a[16:14];
            busy = d == 8'h10 ? 4 : 0;
            win = d == 8'h30;
        end
        if (st == 2 && a == 17'h05555)
            idm = d == 8'h90 || idm && d != 8'hF0;
        st = (st == 0 || st == 3) && a == 17'h05555 && d == 8'hAA ? st + 1
            : (st == 1 || st == 4) && a == 17'h02AAA && d == 8'h55 ? st + 1
            : st == 2 && a == 17'h05555 && d == 8'hA0 ? 6
            : st == 2 && a == 17'h05555 && d == 8'h80 ? 3 : 0;
    endtask
    always @(negedge we_n)
    begin
        expire();
        la = addr;
        tw = $time;
    end
    always @(posedge we_n)
        if (busy == 0)
            cmd(la, dq_o);
    always @(negedge oe_n)
    begin
        expire();
        if (busy == 1)
            for (int i = 0; i < 131072; i++)
                if (er ? sect[i[16:14]] : i == pa)
                    mem[i] = er ? 8'hFF : mem[i] & pd;
        if (busy > 0 || win)
            tog = !tog;
        if (busy > 0 || win)
            q = {!er & ~pd[7], tog, 2'b00, er & !win,
                3'b000};
        else if (idm)
            q = addr[0] ? PT
                : addr[1] ? {7'h00, PR[addr[16:14]]} : MK;
        else
            q = mem[addr];
        busy = busy > 0 ? busy - 1 : 0;
    end
endmodule
`default_nettype wire

// file: tb/flash_command_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module flash_command_sequencer_tb;
    logic aclk, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [16:0] flash_addr;
    logic [7:0] flash_dq_i, flash_dq_o;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
    int err_count = 0, samples_checked = 0, n;
    fcs_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_addr, .flash_dq_i,
        .flash_dq_o, .flash_dq_oe, .flash_ce_n, .flash_we_n, .flash_oe_n);
    fcs_flash_model fm (.addr(flash_addr), .dq_o(flash_dq_o),
        .we_n(flash_we_n), .oe_n(flash_oe_n), .dq_i(flash_dq_i));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid && !s_axi_awready
            || s_axi_wvalid && !s_axi_wready);
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    // Runs one operation, waits for done, checks fail flag and result byte
    task automatic op(input logic [2:0] o, input logic [16:0] a,
        input logic [7:0] d, s, e);
        wr(8'h04, {15'h0000, a});
        wr(8'h08, {24'h000000, d});
        wr(8'h0C, {24'h000000, s});
        wr(8'h00, {23'h000000, 1'b1, 5'h00, o});
        n = 0;
        do
        begin
            rd(8'h10);
            n++;
        end while (v[1] !== 1'b1 && n < 9000);
        chk("status", 32'h2, v[2:0]);
        if (o > 3'h2) chk("poll", e, v[15:8]);
        rd(8'h14);
        chk("rdata", e, v[7:0]);
        $display("op %0d at %h ends", o, a);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    initial
    begin
        #1000000;
        err_count++;
        final_report();
    end
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h20);
        chk("unmapped", 2'h2, r);
        wr(8'h20, 32'h0);
        chk("bresp", 2'h2, r);
        op(3'h0, 17'h00010, 8'h00, 8'h00, 8'hFF);
        op(3'h2, 17'h00000, 8'h00, 8'h00, 8'h07);
        op(3'h2, 17'h00001, 8'h00, 8'h00, 8'h8A);
        op(3'h2, 17'h04002, 8'h00, 8'h00, 8'h01);
        op(3'h2, 17'h00002, 8'h00, 8'h00, 8'h00);
        op(3'h0, 17'h00000, 8'h00, 8'h00, 8'hFF);
        op(3'h3, 17'h04005, 8'hBC, 8'h00, 8'hBC);
        op(3'h3, 17'h00010, 8'h5A, 8'h00, 8'h5A);
        op(3'h3, 17'h04005, 8'hF3, 8'h00, 8'hB0);
        op(3'h5, 17'h04000, 8'h00, 8'h06, 8'hFF);
        op(3'h0, 17'h04005, 8'h00, 8'h00, 8'hFF);
        op(3'h0, 17'h00010, 8'h00, 8'h00, 8'h5A);
        op(3'h4, 17'h00010, 8'h00, 8'h00, 8'hFF);
        wr(8'h00, 32'h00000105);
        rd(8'h10);
        chk("reject", 32'h8, v[3:0]);
        final_report();
    end
endmodule
`default_nettype wire
